// file: core/adc_scan_sequencer.sv
// Purpose: burst and trigger-driven scan sequencer with per-channel mailbox
// Assumes: inputs synchronous to I_CLK; converter result valid 5 us after a convert pulse
// Notes:   mailbox and flags live in flip-flops; all times counted on a 1 us tick
//
// Summary of operation
// [RULE1] differential burst continuous alternates mailbox halves per pass
// [RULE2] per-channel interrupt every conversion in burst
// [RULE3] group interrupt 20 us after last start
// [RULE4] host avoids per-channel interrupts in burst modes
// [RULE5] burst single: one ascending pass, 15 us
// [RULE6] burst single differential fills lower half only
// [RULE7] burst starts on trigger or start bit
// [RULE8] trigger-only: one conversion per falling edge
// [RULE9] trigger-only spacing comes from trigger edges only
// [RULE10] host clears timer and trigger direction first
// [RULE11] host waits 5 us before first trigger
// [RULE12] trigger stores previous result, starts next
// [RULE13] first trigger writes nothing; extra trigger flushes
// [RULE14] start bit only arms trigger-only mode
// [RULE15] per-channel interrupt 5 us after trigger
// [RULE16] group interrupt 5 us after flushing trigger
// [RULE17] trigger-only differential alternates mailbox halves
// [RULE18] burst master drives trigger line as output
// [RULE19] scan mode zero stops scanning
// [RULE20] interval timer spaces burst continuous passes
// [RULE21] new-data and missed-data flags per slot
// [RULE22] channel counter reloads start after end
`timescale 1ns/10ps
`default_nettype none

module adc_scan_sequencer
	import adc_seq_pkg::*;
(
	// clock and reset
	input  wire logic     I_CLK,
	input  wire logic     I_RESETN,
	// register port
	input  wire reg_req_t I_REG,
	output logic [15:0]   O_RDATA,
	// converter
	input  wire logic [15:0] I_ADC_DATA,
	output adc_cmd_t      O_ADC,
	// shared trigger line
	input  wire logic     I_SYNC_STROBE_N,
	output logic          O_SYNC_STROBE_N,
	output logic          O_SYNC_STROBE_OE,
	// interrupt request pulse
	output logic          O_IRQ
);

	typedef struct packed {
		seq_state_t        state;
		logic [15:0]       ctrl;
		logic [15:0]       range;
		logic [15:0]       interval;
		logic [7:0]        us_cnt;
		logic [15:0]       step_cnt;
		logic [4:0]        chan;
		logic              half;
		logic              first;
		logic [15:0]       hold;
		logic              conv_busy;
		logic [2:0]        conv_cnt;
		logic [4:0]        conv_slot;
		logic [4:0]        prev_slot;
		logic              prev_last;
		logic              irq_pend;
		logic [4:0]        irq_cnt;
		logic [4:0]        irq_due;
		logic [31:0]       new_flags;
		logic [31:0]       miss_flags;
		logic [31:0][15:0] mbox;
		logic              trig_prev;
		logic [15:0]       rdata;
		adc_cmd_t          adc;
		logic              strobe_n;
		logic              strobe_oe;
		logic              irq;
	} state_t;

	state_t q;
	state_t d;

	// mailbox slot of a channel: differential uses the half bit as slot msb
	function automatic logic [4:0] slot_of(input logic [4:0] ch, input logic hf, input logic df);
		slot_of = df ? {hf, ch[3:0]} : ch;
	endfunction

	always_comb begin
		scan_mode_t  mode;
		irq_sel_t    irq_sel;
		logic        diff;
		logic        burst;
		logic        tick;
		logic        trig_in;
		logic        start_req;
		logic [4:0]  start_ch;
		logic [4:0]  end_ch;
		logic        launch;
		logic [4:0]  launch_ch;
		logic        launch_hf;
		logic        mb_we;
		logic [4:0]  mb_slot;
		logic [15:0] mb_data;
		logic        arm_irq;
		logic [4:0]  arm_due;
		logic        in_mbox;
		logic [4:0]  rd_slot;

		d = q;
		mode      = scan_mode_t'(q.ctrl[CTL_MODE +: 3]);
		irq_sel   = irq_sel_t'(q.ctrl[CTL_IRQ +: 2]);
		diff      = (q.ctrl[CTL_INSEL +: 3] == INSEL_DIFF);
		burst     = (mode == MODE_BURST_CONT) || (mode == MODE_BURST_SINGLE);
		tick      = (q.us_cnt == US_LAST);
		start_ch  = q.range[RNG_START +: 5];
		end_ch    = q.range[RNG_END +: 5];
		start_req = I_REG.wr && (I_REG.addr == OFS_START) && I_REG.wdata[0];
		// trigger edge counts only while the pin is an input
		trig_in   = !q.ctrl[CTL_TRIG_OUT] && q.trig_prev && !I_SYNC_STROBE_N; // [RULE8]
		launch    = 1'b0;
		launch_ch = q.chan;
		launch_hf = q.half;
		mb_we     = 1'b0;
		mb_slot   = q.conv_slot;
		mb_data   = q.hold;
		arm_irq   = 1'b0;
		arm_due   = EXT_IRQ_US;
		in_mbox   = (I_REG.addr >= OFS_MBOX_LO) && (I_REG.addr <= OFS_MBOX_HI) && !I_REG.addr[0];
		rd_slot   = I_REG.addr[5:1];

		// pulses default low, microsecond prescaler restarted at each burst launch
		d.adc.convert = 1'b0;
		d.irq         = 1'b0;
		d.trig_prev   = I_SYNC_STROBE_N;
		d.us_cnt      = tick ? 8'h00 : 8'(q.us_cnt + 8'h01);
		if (tick) begin
			d.step_cnt = 16'(q.step_cnt + 16'h0001);
			d.strobe_n = 1'b1; // strobe pulse ends at the next tick
		end

		// register writes
		if (I_REG.wr) begin
			unique case (I_REG.addr)
				OFS_CONTROL:  d.ctrl = I_REG.wdata;
				OFS_RANGE:    d.range = I_REG.wdata;
				OFS_INTERVAL: d.interval = I_REG.wdata;
				default:      ;
			endcase
		end

		// register reads, answered one cycle later
		d.rdata = 16'h0000;
		if (I_REG.rd) begin
			if (in_mbox) begin
				d.rdata = q.mbox[rd_slot];
				d.new_flags[rd_slot] = 1'b0; // reading consumes the new-data mark
			end else begin
				unique case (I_REG.addr)
					OFS_CONTROL:  d.rdata = q.ctrl;
					OFS_RANGE:    d.rdata = q.range;
					OFS_NEW_LO:   d.rdata = q.new_flags[15:0];
					OFS_NEW_HI:   d.rdata = q.new_flags[31:16];
					OFS_MISS_LO: begin
						d.rdata = q.miss_flags[15:0];
						d.miss_flags[15:0] = 16'h0000;
					end
					OFS_MISS_HI: begin
						d.rdata = q.miss_flags[31:16];
						d.miss_flags[31:16] = 16'h0000;
					end
					OFS_START:    d.rdata = {15'h0000, q.state != ST_IDLE};
					OFS_INTERVAL: d.rdata = q.interval;
					default:      d.rdata = 16'h0000;
				endcase
			end
		end

		// conversion in flight: result is taken 5 us after the convert pulse in burst modes, 4 to 5 us after it in trigger-only mode
		if (q.conv_busy && tick) begin
			d.conv_cnt = 3'(q.conv_cnt + 3'h1);
			if (q.conv_cnt == CONV_US - 3'h1) begin
				d.conv_busy = 1'b0;
				d.hold      = I_ADC_DATA;
				if (q.state != ST_EXT) begin
					// burst modes store the result straight away
					mb_we   = 1'b1;
					mb_slot = q.conv_slot;
					mb_data = I_ADC_DATA;
					if (irq_sel == IRQ_CHANNEL)
						d.irq = 1'b1; // one per conversion, so every 15 us within a pass [RULE2]
				end
			end
		end

		// scan sequencer
		unique case (q.state)
			ST_IDLE: begin
				if (burst && (start_req || trig_in)) begin
					// first pass always lands in the lower half [RULE6]
					d.half    = 1'b0;
					launch    = 1'b1;
					launch_ch = start_ch;
					launch_hf = 1'b0;
					d.chan    = start_ch;
					d.state   = ST_BURST; // [RULE7]
				end else if ((mode == MODE_EXT_ONLY) && start_req) begin
					// start bit only arms, no conversion here
					d.state = ST_EXT; // [RULE14]
					d.first = 1'b1;
					d.chan  = start_ch;
					d.half  = 1'b0;
				end
			end
			ST_BURST: begin
				if (!burst) begin
					d.state = ST_IDLE; // [RULE19]
				end else if (tick && (q.step_cnt == BURST_SPACING_US - 16'h0001)) begin
					if (q.chan == end_ch) begin
						d.chan = start_ch; // [RULE22]
						if (mode == MODE_BURST_CONT) begin
							d.half     = q.half ^ diff; // [RULE1]
							d.state    = ST_GAP;
							d.step_cnt = 16'h0000;
						end else begin
							d.state = ST_IDLE; // single pass done [RULE5]
						end
					end else begin
						// ascending order, fixed 15 us spacing [RULE5]
						d.chan    = 5'(q.chan + 5'h01);
						launch    = 1'b1;
						launch_ch = 5'(q.chan + 5'h01);
					end
				end
			end
			ST_GAP: begin
				if (mode != MODE_BURST_CONT) begin
					d.state = ST_IDLE; // [RULE19]
				end else if (!q.ctrl[CTL_TIMER_EN] || (q.step_cnt >= q.interval)) begin
					// pass-to-pass delay from the interval register [RULE20]
					launch  = 1'b1;
					d.state = ST_BURST;
				end
			end
			ST_EXT: begin
				if (mode != MODE_EXT_ONLY) begin
					d.state = ST_IDLE; // [RULE19]
				end else if (trig_in) begin
					// spacing set purely by trigger edges [RULE9]
					if (!q.first) begin
						// store the previous result as the new one starts [RULE12]
						mb_we   = 1'b1;
						mb_slot = q.prev_slot;
						mb_data = q.hold;
						if (irq_sel == IRQ_CHANNEL)
							arm_irq = 1'b1; // [RULE15]
						if ((irq_sel == IRQ_GROUP) && q.prev_last)
							arm_irq = 1'b1; // [RULE16]
					end
					d.first     = 1'b0; // nothing written on the first edge [RULE13]
					launch      = 1'b1;
					d.prev_slot = slot_of(q.chan, q.half, diff);
					d.prev_last = (q.chan == end_ch);
					if (q.chan == end_ch) begin
						d.chan = start_ch; // [RULE22]
						d.half = q.half ^ diff; // [RULE17]
					end else begin
						d.chan = 5'(q.chan + 5'h01); // [RULE8]
					end
				end
			end
			default: d.state = ST_IDLE;
		endcase

		// start of one conversion
		if (launch) begin
			d.adc.convert = 1'b1;
			d.adc.chan    = launch_ch;
			d.conv_busy   = 1'b1;
			d.conv_cnt    = 3'h0;
			d.conv_slot   = slot_of(launch_ch, launch_hf, diff);
			if (q.state != ST_EXT) begin
				d.step_cnt = 16'h0000;
				// restart the prescaler so 15 us spacing and 20 us delay are whole ticks [RULE5]
				d.us_cnt   = 8'h00;
				// burst master pulses the shared line for its followers
				d.strobe_n = !q.ctrl[CTL_TRIG_OUT]; // [RULE18]
				if ((irq_sel == IRQ_GROUP) && (launch_ch == end_ch)) begin
					arm_irq = 1'b1; // [RULE3]
					arm_due = GROUP_IRQ_US;
				end
			end
		end

		// delayed interrupt timer; a new arm restarts it
		if (q.irq_pend && tick) begin
			d.irq_cnt = 5'(q.irq_cnt + 5'h01);
			if (q.irq_cnt == q.irq_due - 5'h01) begin
				d.irq      = 1'b1;
				d.irq_pend = 1'b0;
			end
		end
		if (arm_irq) begin
			d.irq_pend = 1'b1;
			d.irq_cnt  = 5'h00;
			d.irq_due  = arm_due;
		end

		// mailbox write after the read clears, so a write in the same cycle wins
		if (mb_we) begin
			d.mbox[mb_slot]       = mb_data;
			d.miss_flags[mb_slot] = q.new_flags[mb_slot] | d.miss_flags[mb_slot]; // [RULE21]
			d.new_flags[mb_slot]  = 1'b1; // [RULE21]
		end

		// line is driven only when programmed as output
		d.strobe_oe = q.ctrl[CTL_TRIG_OUT]; // [RULE18]
		if (!q.ctrl[CTL_TRIG_OUT])
			d.strobe_n = 1'b1;
	end

	// single state register
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			q            <= '0;
			q.state      <= ST_IDLE;
			q.ctrl       <= CONTROL_RST;
			q.range      <= RANGE_RST;
			q.interval   <= INTERVAL_RST;
			q.trig_prev  <= 1'b1;
			q.strobe_n   <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign O_RDATA          = q.rdata;
	assign O_ADC            = q.adc;
	assign O_SYNC_STROBE_N  = q.strobe_n;
	assign O_SYNC_STROBE_OE = q.strobe_oe;
	assign O_IRQ            = q.irq;

endmodule

`default_nettype wire

// file: shared/adc_seq_pkg.sv
// Purpose: constants, register map and carrier types of the burst/trigger scan sequencer
// Assumes: 250 MHz system clock, 16-bit register data, byte addresses as printed
// Notes:   all times are held in microseconds and counted with one microsecond tick
package adc_seq_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS = 4;
	localparam int US_NS         = 1000;
	localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);

	// sequencer times in microseconds
	localparam logic [15:0] BURST_SPACING_US = 16'd15;
	localparam logic [2:0]  CONV_US          = 3'd5;
	localparam logic [4:0]  GROUP_IRQ_US     = 5'd20;
	localparam logic [4:0]  EXT_IRQ_US       = 5'd5;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_RANGE    = 8'h06;
	localparam logic [7:0] OFS_NEW_LO   = 8'h08;
	localparam logic [7:0] OFS_NEW_HI   = 8'h0a;
	localparam logic [7:0] OFS_MISS_LO  = 8'h0c;
	localparam logic [7:0] OFS_MISS_HI  = 8'h0e;
	localparam logic [7:0] OFS_START    = 8'h10;
	localparam logic [7:0] OFS_INTERVAL = 8'h12;
	localparam logic [7:0] OFS_MBOX_LO  = 8'h40;
	localparam logic [7:0] OFS_MBOX_HI  = 8'h7e;

	// control register fields
	localparam int CTL_TRIG_OUT = 2;
	localparam int CTL_INSEL    = 3;
	localparam int CTL_MODE     = 8;
	localparam int CTL_TIMER_EN = 11;
	localparam int CTL_IRQ      = 12;
	localparam logic [2:0] INSEL_DIFF = 3'h0;

	// range register fields
	localparam int RNG_START = 0;
	localparam int RNG_END   = 8;

	// reset values
	localparam logic [15:0] CONTROL_RST  = 16'h0000;
	localparam logic [15:0] RANGE_RST    = 16'h0000;
	localparam logic [15:0] INTERVAL_RST = 16'h0000;

	typedef enum logic [2:0] {
		MODE_OFF          = 3'h0,
		MODE_UNI_CONT     = 3'h1,
		MODE_UNI_SINGLE   = 3'h2,
		MODE_BURST_CONT   = 3'h3,
		MODE_BURST_SINGLE = 3'h4,
		MODE_EXT_ONLY     = 3'h5
	} scan_mode_t;

	typedef enum logic [1:0] {
		IRQ_NONE    = 2'h0,
		IRQ_CHANNEL = 2'h1,
		IRQ_GROUP   = 2'h2
	} irq_sel_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_BURST = 4'b0010,
		ST_GAP   = 4'b0100,
		ST_EXT   = 4'b1000
	} seq_state_t;

	// register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// converter command
	typedef struct packed {
		logic       convert;
		logic [4:0] chan;
	} adc_cmd_t;

endpackage

// file: verification/adc_scan_sequencer_chk.sv
// Purpose: port assertions for the scan sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   control and range writes are shadowed to know the mode
`timescale 1ns/10ps
`default_nettype none
module adc_scan_sequencer_chk
	import adc_seq_pkg::*;
(
	input wire logic        I_CLK,
	input wire logic        I_RESETN,
	input wire reg_req_t    I_REG,
	input wire logic [15:0] O_RDATA,
	input wire logic [15:0] I_ADC_DATA,
	input wire adc_cmd_t    O_ADC,
	input wire logic        I_SYNC_STROBE_N,
	input wire logic        O_SYNC_STROBE_N,
	input wire logic        O_SYNC_STROBE_OE,
	input wire logic        O_IRQ
);
	logic [15:0] ctl_q;
	logic [15:0] rng_q;
	logic [15:0] gap_q;
	logic [15:0] end_q;
	logic        off_q;
	logic        burst;
	logic        ext;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);
	// mode decode from the shadow
	assign burst = ctl_q[10:8] == 3'h3 || ctl_q[10:8] == 3'h4;
	assign ext   = ctl_q[10:8] == 3'h5;
	// counters saturate so a long idle never wraps into a checked window
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ctl_q <= CONTROL_RST;
			rng_q <= RANGE_RST;
			gap_q <= 16'hffff;
			end_q <= 16'hffff;
			off_q <= 1'b1;
		end else begin
			off_q <= ctl_q[10:8] == 3'h0;
			if (I_REG.wr && I_REG.addr == OFS_CONTROL)
				ctl_q <= I_REG.wdata;
			if (I_REG.wr && I_REG.addr == OFS_RANGE)
				rng_q <= I_REG.wdata;
			gap_q <= O_ADC.convert ? 16'h0000 : gap_q + 16'(gap_q != 16'hffff);
			end_q <= (O_ADC.convert && O_ADC.chan == rng_q[12:8]) ? 16'h0000 : end_q + 16'(end_q != 16'hffff);
		end
	end
	// drive enable is registered from the stored control word, so it follows two edges after the write
	a_ctl_oe: assert property (I_REG.wr && I_REG.addr == OFS_CONTROL |-> ##2
		O_SYNC_STROBE_OE == $past(I_REG.wdata[CTL_TRIG_OUT], 2)) else $error("drive enable not from control");
	a_strobe_idle: assert property (!O_SYNC_STROBE_OE |-> O_SYNC_STROBE_N) else $error("strobe low undriven");
	a_strobe_conv: assert property (O_ADC.convert && O_SYNC_STROBE_OE |-> !O_SYNC_STROBE_N)
		else $error("no strobe with convert");
	a_trig_conv: assert property (ext && O_ADC.convert |-> $past(I_SYNC_STROBE_N) == 1'b0
		&& $past(I_SYNC_STROBE_N, 2)) else $error("convert without trigger edge");
	a_burst_gap: assert property (burst && O_ADC.convert && gap_q < 16'd4000 |-> gap_q == 16'd3749)
		else $error("burst spacing wrong");
	a_group_irq: assert property (O_IRQ && burst && ctl_q[13:12] == 2'h2 |->
		end_q >= 16'd4740 && end_q <= 16'd5010) else $error("group interrupt timing");
	a_ext_irq: assert property (O_IRQ && ext |-> gap_q >= 16'd990 && gap_q <= 16'd1260)
		else $error("trigger interrupt timing");
	a_irq_pulse: assert property (O_IRQ |=> !O_IRQ) else $error("interrupt not a pulse");
	a_chan_step: assert property (O_ADC.convert |-> O_ADC.chan == $past(O_ADC.chan) + 5'd1
		|| O_ADC.chan == rng_q[4:0]) else $error("channel order");
	a_chan_wrap: assert property (O_ADC.convert && $past(O_ADC.chan) == rng_q[12:8] |->
		O_ADC.chan == rng_q[4:0]) else $error("no reload after end");
	a_mode_off: assert property (off_q && ctl_q[10:8] == 3'h0 |-> !O_ADC.convert) else $error("convert while off");
	c_burst: cover property (burst && O_ADC.convert);
	c_ext_irq: cover property (ext && O_IRQ);
	c_group: cover property (burst && O_IRQ);
	c_cont: cover property (ctl_q[10:8] == 3'h3 && O_ADC.convert && O_ADC.chan == rng_q[4:0]);
endmodule
bind adc_scan_sequencer adc_scan_sequencer_chk chk (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_REG(I_REG),
	.O_RDATA(O_RDATA), .I_ADC_DATA(I_ADC_DATA), .O_ADC(O_ADC), .I_SYNC_STROBE_N(I_SYNC_STROBE_N),
	.O_SYNC_STROBE_N(O_SYNC_STROBE_N), .O_SYNC_STROBE_OE(O_SYNC_STROBE_OE), .O_IRQ(O_IRQ));
`default_nettype wire

// file: verification/adc_conv_model.sv
// Purpose: behavioural converter beside the sequencer
// Assumes: result ready READY cycles after a convert pulse
// Notes:   result is convert index and channel, so every word is traceable
`timescale 1ns/10ps
`default_nettype none
module adc_conv_model
	import adc_seq_pkg::*;
#(
	parameter int READY = 990
)(
	input  wire logic     i_clk,
	input  wire adc_cmd_t i_cmd,
	output logic [15:0]   o_data
);
	logic [15:0] res_q = 16'h0000;
	logic [15:0] idx_q = 16'h0000;
	logic [15:0] cnt_q = 16'h0000;
	// a new convert restarts the conversion and drops the old result
	always_ff @(posedge i_clk) begin
		if (i_cmd.convert) begin
			res_q <= {idx_q[10:0], i_cmd.chan};
			idx_q <= idx_q + 16'h0001;
			cnt_q <= 16'h0000;
		end else if (cnt_q < 16'(READY)) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	// output churns while converting so an early sample cannot match by luck
	assign o_data = (cnt_q >= 16'(READY)) ? res_q : (cnt_q ^ 16'h5a5a);
endmodule
`default_nettype wire

// file: verification/adc_burst_trigger_scan_sequencer_tb.sv
// Purpose: self-checking bench for the scan sequencer
// Assumes: 250 MHz clock, converter model on the far side
// Notes:   notes queue up as stimulus goes out; a monitor retires them
`timescale 1ns/10ps
`default_nettype none
module adc_burst_trigger_scan_sequencer_tb
	import adc_seq_pkg::*;
;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	reg_req_t    req = '0;
	adc_cmd_t    cmd;
	logic [15:0] rdata;
	logic [15:0] adc_data;
	logic        strobe_n = 1'b1;
	logic        dut_strobe_n;
	logic        dut_oe;
	logic        line_n;
	logic        irq;
	logic        rd_seen = 1'b0;
	logic [31:0] seed = 32'had3f;
	int          n_mismatch = 0;
	int          checks = 0;
	int          n_irq = 0;
	logic [15:0] rd_q[$];
	logic [15:0] ch_q[$];
	always #2 clk = ~clk;
	// pulled-up shared line; the sequencer wins while it drives
	assign line_n = dut_oe ? dut_strobe_n : strobe_n;
	adc_scan_sequencer dut (.I_CLK(clk), .I_RESETN(resetn), .I_REG(req), .O_RDATA(rdata),
		.I_ADC_DATA(adc_data), .O_ADC(cmd), .I_SYNC_STROBE_N(line_n), .O_SYNC_STROBE_N(dut_strobe_n),
		.O_SYNC_STROBE_OE(dut_oe), .O_IRQ(irq));
	adc_conv_model conv (.i_clk(clk), .i_cmd(cmd), .o_data(adc_data));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic compare(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= {a, d, wr, !wr};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic read_exp(input logic [7:0] a, input logic [15:0] exp);
		rd_q.push_back(exp);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 20000 && irq !== 1'b1; i++)
			@(posedge clk);
		if (irq !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
		@(posedge clk);
	endtask
	// random spacing above the settle time of the converter, random width of 2 to 5 cycles
	task automatic trig();
		seed = lfsr(seed);
		repeat (1500 + seed[7:0]) @(posedge clk);
		strobe_n <= 1'b0;
		repeat (2 + seed[9:8]) @(posedge clk);
		strobe_n <= 1'b1;
	endtask
	// retire the oldest note whenever a result appears; an empty queue never matches
	always @(posedge clk) begin
		if (rd_seen)
			compare(rdata, rd_q.size() ? rd_q.pop_front() : 16'hxxxx);
		if (cmd.convert === 1'b1)
			compare({11'h000, cmd.chan}, ch_q.size() ? ch_q.pop_front() : 16'hxxxx);
		if (irq === 1'b1)
			n_irq++;
		rd_seen = req.rd;
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		read_exp(OFS_CONTROL, CONTROL_RST);
		read_exp(8'h02, 16'h0000);
		// burst single, differential, channels 2..4, group interrupt, line driven
		bus(1'b1, OFS_RANGE, 16'h0402);
		bus(1'b1, OFS_CONTROL, 16'h2404);
		for (int r = 0; r < 2; r++) begin
			for (int c = 2; c < 5; c++)
				ch_q.push_back(16'(c));
			bus(1'b1, OFS_START, 16'h0001);
			read_exp(OFS_START, 16'h0001);
			wait_irq();
			read_exp(r ? OFS_MISS_LO : OFS_NEW_LO, 16'h001c);
		end
		read_exp(OFS_MISS_LO, 16'h0000);
		read_exp(OFS_NEW_HI, 16'h0000);
		for (int c = 2; c < 5; c++)
			read_exp(8'h40 + 8'(2 * c), 16'(32 * (c + 1) + c));
		read_exp(OFS_NEW_LO, 16'h0000);
		// trigger-only, channels 0..1, per-channel interrupt, line in, timer off
		bus(1'b1, OFS_RANGE, 16'h0100);
		bus(1'b1, OFS_CONTROL, 16'h1500);
		bus(1'b1, OFS_START, 16'h0001);
		repeat (1250) @(posedge clk);
		for (int k = 0; k < 5; k++) begin
			ch_q.push_back(16'(k % 2));
			trig();
		end
		wait_irq();
		compare(16'(n_irq), 16'h0006);
		read_exp(OFS_NEW_HI, 16'h0003);
		read_exp(8'h40, 16'h00c0);
		read_exp(8'h42, 16'h00e1);
		read_exp(8'h60, 16'h0100);
		read_exp(8'h62, 16'h0121);
		// burst continuous, differential, channels 5..6, group interrupt, trigger start, 8 us gap
		repeat (2500) @(posedge clk);
		bus(1'b1, OFS_RANGE, 16'h0605);
		bus(1'b1, OFS_INTERVAL, 16'h0008);
		bus(1'b1, OFS_CONTROL, 16'h2b00);
		for (int p = 0; p < 2; p++) begin
			ch_q.push_back(16'h0005);
			ch_q.push_back(16'h0006);
		end
		trig();
		wait_irq();
		wait_irq();
		// stop before the third pass would launch; any extra convert finds an empty note queue
		bus(1'b1, OFS_CONTROL, 16'h0000);
		read_exp(OFS_NEW_HI, 16'h0060);
		read_exp(8'h4a, 16'h0165);
		read_exp(8'h4c, 16'h0186);
		read_exp(8'h6a, 16'h01a5);
		read_exp(8'h6c, 16'h01c6);
		repeat (1000) @(posedge clk);
		compare(16'(ch_q.size() + rd_q.size()), 16'h0000);
		wrap_up();
	end
endmodule
`default_nettype wire
